// file: rtl/fpmau_top.sv
`timescale 1ns/1ps
module fpmau_top import fpmau_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic wb_valid,
  output logic [4:0] wb_index,
  output logic [63:0] wb_data
);
  function automatic fpmau_unp_t unpack(input logic [63:0] r, input logic ps);
    fpmau_unp_t u;
    logic [10:0] e;
    logic [51:0] f;
    logic emx;
    e = ps ? {3'h0, r[62:55]} : r[62:52];
    f = ps ? {r[54:32], 29'h0} : r[51:0];
    emx = ps ? (e == 11'h0ff) : (e == 11'h7ff);
    u.sgn = r[63];
    u.exp = signed'({2'h0, (e == 11'h0) ? 11'h001 : e}) - (ps ? BIAS_S : BIAS_D);
    u.man = {e != 11'h0, f};
    u.zero = (e == 11'h0) && (f == 52'h0);
    u.inf = emx && (f == 52'h0);
    u.nan = emx && (f != 52'h0);
    u.snan = u.nan && !f[51];
    return u;
  endfunction : unpack

  fpmau_state_t state_reg;
  fpmau_ins_t ins_reg, ins_w;
  logic [1:0] ctrl_reg;
  logic [31:0] fp_status_control_reg_reg, nf;
  logic [63:0] a_reg, b_reg, c_reg, d_reg;
  logic [3:0] cr1_reg;
  logic illegal_reg;
  logic [31:0] rdata, wm;
  logic take, wr, legal;

  // Every access waits one cycle, and all of them wait while an operation runs,
  // so operands and the status register never change under the datapath.
  assign take = (avs_read || avs_write) && avs_waitrequest && state_reg == ST_IDLE;
  assign wr = take && avs_write;
  assign ins_w = fpmau_ins_t'(wm);
  assign legal = (ins_w.op == OP_SINGLE && (ins_w.xo == XO_MADD || ins_w.xo == XO_MSUB
                 || (ins_w.xo == XO_MUL && ins_w.sb == 5'h00)))
              || (ins_w.op == OP_DOUBLE && (ins_w.xo == XO_MSUB
                 || (ins_w.xo == XO_MUL && ins_w.sb == 5'h00)))
              || (ins_w.op == OP_DOUBLE && {ins_w.sc, ins_w.xo} == XO_MOVE);

  always_comb begin
    rdata = 32'h0;
    case (avs_address)
      ADDR_CTRL: rdata = {30'h0, ctrl_reg};
      ADDR_FP_STATUS_CONTROL_REG: rdata = fp_status_control_reg_reg;
      ADDR_A_HI: rdata = a_reg[63:32];
      ADDR_A_LO: rdata = a_reg[31:0];
      ADDR_B_HI: rdata = b_reg[63:32];
      ADDR_B_LO: rdata = b_reg[31:0];
      ADDR_C_HI: rdata = c_reg[63:32];
      ADDR_C_LO: rdata = c_reg[31:0];
      ADDR_D_HI: rdata = d_reg[63:32];
      ADDR_D_LO: rdata = d_reg[31:0];
      ADDR_INSTR: rdata = ins_reg;
      ADDR_STATUS: rdata = {19'h0, ins_reg.dst, cr1_reg, 2'h0, illegal_reg,
                            state_reg != ST_IDLE};
      default: rdata = 32'h0;
    endcase
    wm = rdata;
    for (int i = 0; i < 4; i++) begin
      if (avs_byteenable[i]) begin
        wm[8*i+:8] = avs_writedata[8*i+:8];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end else begin
      avs_waitrequest <= !take;
      if (take && avs_read) begin
        avs_readdata <= rdata;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RESET;
      a_reg <= 64'h0;
      b_reg <= 64'h0;
      c_reg <= 64'h0;
    end else if (wr) begin
      case (avs_address)
        ADDR_CTRL: ctrl_reg <= wm[1:0];
        ADDR_A_HI: a_reg[63:32] <= wm;
        ADDR_A_LO: a_reg[31:0] <= wm;
        ADDR_B_HI: b_reg[63:32] <= wm;
        ADDR_B_LO: b_reg[31:0] <= wm;
        ADDR_C_HI: c_reg[63:32] <= wm;
        ADDR_C_LO: c_reg[31:0] <= wm;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      ins_reg <= fpmau_ins_t'(32'h0);
      illegal_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: if (wr && avs_address == ADDR_INSTR) begin
          ins_reg <= ins_w;
          illegal_reg <= !legal;
          if (legal) begin
            state_reg <= ST_MUL;
          end
        end
        ST_MUL: state_reg <= ST_NRM;
        ST_NRM: state_reg <= ST_RND;
        ST_RND: state_reg <= ST_IDLE;
      endcase
    end
  end

  logic sgl, ps, is_mul, is_sub, is_move, paired_single_enable, bpair;
  assign paired_single_enable = ctrl_reg[CTRL_PSE];
  assign bpair = ctrl_reg[CTRL_BPAIR];
  assign sgl = ins_reg.op == OP_SINGLE;
  assign ps = sgl && paired_single_enable;
  assign is_mul = ins_reg.xo == XO_MUL && !is_move;
  assign is_sub = ins_reg.xo == XO_MSUB;
  assign is_move = ins_reg.op == OP_DOUBLE && {ins_reg.sc, ins_reg.xo} == XO_MOVE;

  fpmau_unp_t ua, ub, uc;
  logic [105:0] prod;
  logic signed [12:0] ep, ed, sh;
  logic [52:0] bm;
  logic [163:0] px, bx;
  logic [327:0] shd;
  logic [7:0] shc;
  logic sp, sb, swap, anynan, snan, imz, isi, pinf, binf;
  assign ua = unpack(a_reg, ps);
  assign ub = unpack(b_reg, ps);
  assign uc = unpack(c_reg, ps);
  assign prod = ua.man * uc.man;
  assign ep = ua.exp + uc.exp;
  assign ed = ep - ub.exp;
  assign bm = is_mul ? 53'h0 : ub.man;
  assign sp = ua.sgn ^ uc.sgn;
  assign sb = ub.sgn ^ is_sub;
  assign px = {2'h0, prod, 56'h0};
  assign bx = {3'h0, bm, 108'h0};
  assign swap = bm != 53'h0 && (prod == 106'h0 || ed < 0);
  assign sh = swap ? -ed : ed;
  assign shc = (sh[12] || sh > 13'sd164) ? 8'd164 : sh[7:0];
  assign shd = {(swap ? px : bx), 164'h0} >> shc;
  assign anynan = ua.nan || (ub.nan && !is_mul) || uc.nan;
  assign snan = ua.snan || (ub.snan && !is_mul) || uc.snan;
  assign imz = ((ua.inf && uc.zero) || (ua.zero && uc.inf)) && !anynan;
  assign pinf = ua.inf || uc.inf;
  assign binf = ub.inf && !is_mul;
  assign isi = pinf && binf && sp != sb && !imz && !anynan;

  logic [163:0] big_reg, small_reg;
  logic stk_reg, sbig_reg, ssml_reg, zsgn_reg;
  logic signed [12:0] emax_reg;
  logic spec_reg, spnan_reg, spsgn_reg, snan_reg, imz_reg, isi_reg;
  logic [51:0] spf_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      big_reg <= 164'h0;
      small_reg <= 164'h0;
      {stk_reg, sbig_reg, ssml_reg, zsgn_reg} <= 4'h0;
      emax_reg <= 13'sd0;
      {spec_reg, spnan_reg, spsgn_reg, snan_reg, imz_reg, isi_reg} <= 6'h0;
      spf_reg <= 52'h0;
    end else if (state_reg == ST_MUL) begin
      big_reg <= swap ? bx : px;
      small_reg <= shd[327:164];
      stk_reg <= |shd[163:0];
      emax_reg <= swap ? ub.exp : ep;
      sbig_reg <= swap ? sb : sp;
      ssml_reg <= swap ? sp : sb;
      zsgn_reg <= is_mul ? sp : (sp == sb ? sp : fp_status_control_reg_reg[1:0] == 2'h3);
      spec_reg <= anynan || imz || pinf || binf;
      spnan_reg <= anynan || imz || isi;
      snan_reg <= snan;
      imz_reg <= imz;
      isi_reg <= isi;
      // A quiet copy of the first NaN in A, B, C order; other invalid results get the default NaN.
      if (ua.nan) begin
        {spsgn_reg, spf_reg} <= {ua.sgn, 1'b1, ua.man[50:0]};
      end else if (ub.nan && !is_mul) begin
        {spsgn_reg, spf_reg} <= {ub.sgn, 1'b1, ub.man[50:0]};
      end else if (uc.nan) begin
        {spsgn_reg, spf_reg} <= {uc.sgn, 1'b1, uc.man[50:0]};
      end else if (imz || isi) begin
        {spsgn_reg, spf_reg} <= {1'b0, 1'b1, 51'h0};
      end else begin
        {spsgn_reg, spf_reg} <= {pinf ? sp : sb, 52'h0};
      end
    end
  end

  logic effsub;
  logic [163:0] sum;
  logic [7:0] lz;
  logic nsg;
  assign effsub = sbig_reg != ssml_reg;
  always_comb begin
    lz = 8'd0;
    if (!effsub) begin
      sum = big_reg + small_reg;
      nsg = sbig_reg;
    end else if ({big_reg, 1'b0} >= {small_reg, stk_reg}) begin
      sum = big_reg - small_reg - {163'h0, stk_reg};
      nsg = sbig_reg;
    end else begin
      sum = small_reg - big_reg;
      nsg = ssml_reg;
    end
    for (int i = 0; i < 164; i++) begin
      if (sum[i]) begin
        lz = 8'(163 - i);
      end
    end
  end

  logic [163:0] norm_reg;
  logic signed [12:0] nexp_reg;
  logic nsgn_reg, nzero_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      norm_reg <= 164'h0;
      nexp_reg <= 13'sd0;
      {nsgn_reg, nzero_reg} <= 2'h0;
    end else if (state_reg == ST_NRM) begin
      norm_reg <= sum << lz;
      nexp_reg <= emax_reg + 13'sd3 - signed'({5'h0, lz});
      nsgn_reg <= nsg;
      nzero_reg <= sum == 164'h0 && !stk_reg;
    end
  end

  logic [1:0] rm;
  logic [52:0] top, keep, rman;
  logic [53:0] rs54;
  logic signed [12:0] rexp, elim;
  logic g, s, lsb, inc, ovf, unf, ovinf, fi, fr, invalid, block, fin;
  logic fs, fnan, finf, fzero;
  logic signed [12:0] fe;
  logic [51:0] ff;
  logic [63:0] res;
  logic [4:0] cls;
  assign rm = fp_status_control_reg_reg[1:0];
  assign top = norm_reg[163:111];
  assign keep = sgl ? {24'hffffff, 29'h0} : {53{1'b1}};
  assign g = sgl ? norm_reg[139] : norm_reg[110];
  assign s = (sgl ? |norm_reg[138:0] : |norm_reg[109:0]) || stk_reg;
  assign lsb = sgl ? top[29] : top[0];
  always_comb begin
    unique case (rm)
      2'h0: inc = g && (s || lsb);
      2'h1: inc = 1'b0;
      2'h2: inc = !nsgn_reg && (g || s);
      2'h3: inc = nsgn_reg && (g || s);
    endcase
  end
  assign rs54 = {1'b0, top & keep} + (inc ? (sgl ? 54'h20000000 : 54'h1) : 54'h0);
  assign rman = rs54[53] ? rs54[53:1] : rs54[52:0];
  assign rexp = nexp_reg + signed'({12'h0, rs54[53]});
  assign elim = sgl ? BIAS_S : BIAS_D;
  // Tiny results flush to zero with underflow set; gradual underflow is not produced.
  assign ovf = !spec_reg && !nzero_reg && rexp > elim;
  assign unf = !spec_reg && !nzero_reg && rexp < (sgl ? EMIN_S : EMIN_D);
  assign ovinf = rm == 2'h0 || (rm == 2'h2 && !nsgn_reg) || (rm == 2'h3 && nsgn_reg);
  assign fi = !spec_reg && (g || s || ovf || unf);
  assign fr = !spec_reg && inc && !ovf && !unf;
  assign invalid = snan_reg || imz_reg || isi_reg;
  assign block = invalid && fp_status_control_reg_reg[VE];
  assign fin = state_reg == ST_RND;

  always_comb begin
    fs = spec_reg ? spsgn_reg : (nzero_reg ? zsgn_reg : nsgn_reg);
    fnan = spec_reg && spnan_reg;
    finf = (spec_reg && !spnan_reg) || (ovf && ovinf);
    fzero = !spec_reg && (nzero_reg || unf);
    fe = ovf ? elim : rexp;
    ff = spec_reg ? spf_reg : (ovf ? keep[51:0] : rman[51:0]);
    if (fnan || finf) begin
      res = ps ? {2{fs, 8'hff, ff[51:29]}} : {fs, 11'h7ff, ff};
    end else if (fzero) begin
      res = ps ? {2{fs, 31'h0}} : {fs, 63'h0};
    end else begin
      res = ps ? {2{fs, 8'(fe + BIAS_S), ff[51:29]}} : {fs, 11'(fe + BIAS_D), ff};
    end
    if (fnan) begin
      cls = CLS_QNAN;
    end else if (finf) begin
      cls = fs ? CLS_NINF : CLS_PINF;
    end else if (fzero) begin
      cls = fs ? CLS_NZERO : CLS_PZERO;
    end else begin
      cls = fs ? CLS_NNORM : CLS_PNORM;
    end
    nf = fp_status_control_reg_reg;
    nf[SNAN_INVALID_BIT] = nf[SNAN_INVALID_BIT] | snan_reg;
    nf[INF_MINUS_INF_INVALID_BIT] = nf[INF_MINUS_INF_INVALID_BIT] | isi_reg;
    nf[INF_TIMES_ZERO_INVALID_BIT] = nf[INF_TIMES_ZERO_INVALID_BIT] | imz_reg;
    nf[OX] = nf[OX] | ovf;
    nf[UX] = nf[UX] | unf;
    nf[XX] = nf[XX] | (fi && !block);
    nf[FR] = fr && !block;
    nf[FI] = fi && !block;
    if (!block) begin
      nf[RESULT_CLASS_FIELD_LO+:5] = cls;
    end
    nf[VX] = |nf[24:19] || |nf[10:8];
    nf[ENABLED_EXCEPTION_SUMMARY_BIT] = (nf[VX] && nf[VE]) || (nf[OX] && nf[OE]) || (nf[UX] && nf[UE])
           || (nf[ZX] && nf[ZE]) || (nf[XX] && nf[XE]);
    // Only exception bits that newly turn on raise the summary bit.
    nf[FX] = fp_status_control_reg_reg[FX] || |(nf[28:19] & ~fp_status_control_reg_reg[28:19]);
  end

  // Software writes and hardware updates are never in the same cycle, since the
  // bus stalls while the pipeline holds an operation.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fp_status_control_reg_reg <= FP_STATUS_CONTROL_REG_RESET;
      cr1_reg <= 4'h0;
    end else if (wr && avs_address == ADDR_FP_STATUS_CONTROL_REG) begin
      fp_status_control_reg_reg <= wm;
    end else if (fin) begin
      if (!is_move) begin
        fp_status_control_reg_reg <= nf;
      end
      if (ins_reg.rc) begin
        cr1_reg <= is_move ? fp_status_control_reg_reg[31:28] : nf[31:28];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      d_reg <= 64'h0;
      wb_valid <= 1'b0;
    end else begin
      wb_valid <= fin && !(block && !is_move);
      if (wr && avs_address == ADDR_D_HI) begin
        d_reg[63:32] <= wm;
      end else if (wr && avs_address == ADDR_D_LO) begin
        d_reg[31:0] <= wm;
      end else if (fin && is_move) begin
        d_reg <= (paired_single_enable && bpair) ? {b_reg[63:32], d_reg[31:0]} : b_reg;
      end else if (fin && !block) begin
        d_reg <= res;
      end
    end
  end
  assign wb_index = ins_reg.dst;
  assign wb_data = d_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_start;
    wr && avs_address == ADDR_INSTR && legal;
  endsequence
  sequence s_pipe;
    state_reg == ST_MUL ##1 state_reg == ST_NRM ##1 state_reg == ST_RND ##1 state_reg == ST_IDLE;
  endsequence
  property p_pipe; s_start |=> s_pipe; endproperty
  a_pipe: assert property (p_pipe) else $error("pipeline did not run");
  property p_norm;
    fin && !spec_reg && !nzero_reg |-> norm_reg[163];
  endproperty
  a_norm: assert property (p_norm) else $error("result not normalized");
  property p_move_copy; fin && is_move && !(paired_single_enable && bpair) |=> d_reg == $past(b_reg); endproperty
  a_move_copy: assert property (p_move_copy) else $error("move lost data");
  property p_move_ps;
    fin && is_move && paired_single_enable && bpair |=> d_reg == {$past(b_reg[63:32]), $past(d_reg[31:0])};
  endproperty
  a_move_ps: assert property (p_move_ps) else $error("paired move wrong");
  property p_dup; fin && ps && !block |=> d_reg[63:32] == d_reg[31:0] && wb_valid; endproperty
  a_dup: assert property (p_dup) else $error("slots differ");
  property p_move_st; fin && is_move |=> $stable(fp_status_control_reg_reg); endproperty
  a_move_st: assert property (p_move_st) else $error("move changed status");
  property p_rc0; fin && !ins_reg.rc |=> $stable(cr1_reg); endproperty
  a_rc0: assert property (p_rc0) else $error("field one changed");
  property p_rc1; fin && ins_reg.rc && !is_move |=> cr1_reg == fp_status_control_reg_reg[31:28]; endproperty
  a_rc1: assert property (p_rc1) else $error("field one not recorded");
  property p_mul_isi; fin && is_mul |=> fp_status_control_reg_reg[INF_MINUS_INF_INVALID_BIT] == $past(fp_status_control_reg_reg[INF_MINUS_INF_INVALID_BIT]); endproperty
  a_mul_isi: assert property (p_mul_isi) else $error("multiply set isi");
  property p_ve;
    fin && !is_move && block |=> $stable(d_reg) && $stable(fp_status_control_reg_reg[16:12]) && !wb_valid;
  endproperty
  a_ve: assert property (p_ve) else $error("trapped result written");
  property p_wait; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("waitrequest low too long");
endmodule : fpmau_top

// file: rtl/fpmau_pkg.sv
// Function
// - Opcode 59/29: A times C plus B, rounded to single.
// - Opcode 63/28: A times C minus B, rounded to double.
// - Opcode 59/28: A times C minus B, rounded to single.
// - Opcode 63/25: A times C rounded to double; B field is zero.
// - Opcode 59/25: A times C rounded to single.
// - Register move copies all of B when paired mode is off.
// - Paired mode on with double B: move copies B whole.
// - Paired mode on with paired B: copy first slot, keep second slot.
// - Paired single arithmetic uses first slots, result fills both slots.
// - Normalize whenever the result significand top bit is not one.
// - Single forms round to single under the rounding mode field.
// - Double forms round to double under the rounding mode field.
// - Result class set from result unless trapped invalid operation.
// - Record bit copies four summary bits to condition field one.
// - Multiply-add forms update class, rounding and exception status bits.
// - Plain multiply never sets the infinity minus infinity bit.
// - Product adds exponents and multiplies significands.
// - Subtract forms subtract B from the product before rounding.
package fpmau_pkg;
  localparam logic [5:0] OP_SINGLE = 6'h3b;
  localparam logic [5:0] OP_DOUBLE = 6'h3f;
  localparam logic [4:0] XO_MADD = 5'h1d;
  localparam logic [4:0] XO_MSUB = 5'h1c;
  localparam logic [4:0] XO_MUL = 5'h19;
  localparam logic [9:0] XO_MOVE = 10'h048;
  localparam logic [5:0] ADDR_CTRL = 6'h00;
  localparam logic [5:0] ADDR_FP_STATUS_CONTROL_REG = 6'h04;
  localparam logic [5:0] ADDR_A_HI = 6'h08;
  localparam logic [5:0] ADDR_A_LO = 6'h0c;
  localparam logic [5:0] ADDR_B_HI = 6'h10;
  localparam logic [5:0] ADDR_B_LO = 6'h14;
  localparam logic [5:0] ADDR_C_HI = 6'h18;
  localparam logic [5:0] ADDR_C_LO = 6'h1c;
  localparam logic [5:0] ADDR_D_HI = 6'h20;
  localparam logic [5:0] ADDR_D_LO = 6'h24;
  localparam logic [5:0] ADDR_INSTR = 6'h28;
  localparam logic [5:0] ADDR_STATUS = 6'h2c;
  localparam int CTRL_PSE = 0;
  localparam int CTRL_BPAIR = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [31:0] FP_STATUS_CONTROL_REG_RESET = 32'h0;
  localparam int FX = 31, ENABLED_EXCEPTION_SUMMARY_BIT = 30, VX = 29, OX = 28, UX = 27, ZX = 26, XX = 25;
  localparam int SNAN_INVALID_BIT = 24, INF_MINUS_INF_INVALID_BIT = 23, INF_TIMES_ZERO_INVALID_BIT = 20, FR = 18, FI = 17, RESULT_CLASS_FIELD_LO = 12;
  localparam int VE = 7, OE = 6, UE = 5, ZE = 4, XE = 3;
  localparam logic signed [12:0] BIAS_D = 13'sd1023;
  localparam logic signed [12:0] BIAS_S = 13'sd127;
  localparam logic signed [12:0] EMIN_D = -13'sd1022;
  localparam logic signed [12:0] EMIN_S = -13'sd126;
  localparam logic [4:0] CLS_QNAN = 5'h11, CLS_NINF = 5'h09, CLS_NNORM = 5'h08;
  localparam logic [4:0] CLS_NZERO = 5'h12, CLS_PZERO = 5'h02, CLS_PNORM = 5'h04;
  localparam logic [4:0] CLS_PINF = 5'h05;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_MUL = 2'b01, ST_NRM = 2'b11, ST_RND = 2'b10
  } fpmau_state_t;
  typedef struct packed {
    logic [5:0] op;
    logic [4:0] dst;
    logic [4:0] sa;
    logic [4:0] sb;
    logic [4:0] sc;
    logic [4:0] xo;
    logic rc;
  } fpmau_ins_t;
  typedef struct packed {
    logic sgn;
    logic signed [12:0] exp;
    logic [52:0] man;
    logic zero;
    logic inf;
    logic nan;
    logic snan;
  } fpmau_unp_t;
endpackage : fpmau_pkg

// file: dv/fpmau_host_model.sv
`timescale 1ns/1ps
module fpmau_host_model import fpmau_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  output logic [5:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic wb_valid
);
  int wb_count = 0;
  initial begin
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
  end
  always @(posedge clk) begin
    if (rst_n === 1'b1 && wb_valid === 1'b1) begin
      wb_count++;
    end
  end
  // The request is held until waitrequest is sampled low; there is no cycle budget here.
  task automatic finish_access(output logic [31:0] q);
    logic done;
    done = 1'b0;
    q = 32'h0;
    while (!done) begin
      @(posedge clk);
      done = (avs_waitrequest === 1'b0);
      q = avs_readdata;
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // Released lines change so that a stale value cannot pass for a fresh one.
    avs_writedata <= ~avs_writedata;
    avs_byteenable <= ~avs_byteenable;
  endtask : finish_access
  task automatic bus_write(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_write <= 1'b1;
    finish_access(q);
  endtask : bus_write
  task automatic bus_read(input logic [5:0] a, output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_byteenable <= 4'hf;
    avs_read <= 1'b1;
    finish_access(q);
  endtask : bus_read
endmodule : fpmau_host_model

// file: dv/tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb import fpmau_pkg::*;;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic wb_valid;
  logic [4:0] wb_index;
  logic [63:0] wb_data;
  int n_mismatch = 0;
  int n_tests = 0;
  logic [31:0] q;
  always #20 clk = ~clk;
  fpmau_top i_fpmau_top (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .wb_valid(wb_valid), .wb_index(wb_index),
    .wb_data(wb_data));
  fpmau_host_model i_fpmau_host_model (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .wb_valid(wb_valid));
  function automatic logic [31:0] ins(input logic [5:0] op, input logic [4:0] d,
    input logic [4:0] a, input logic [4:0] b, input logic [4:0] c, input logic [4:0] x,
    input logic rc);
    return {op, d, a, b, c, x, rc};
  endfunction : ins
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    i_fpmau_host_model.bus_write(a, d, 4'hf);
  endtask : wr
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    i_fpmau_host_model.bus_read(a, d);
  endtask : rd
  task automatic set_ops(input logic [63:0] a, input logic [63:0] b, input logic [63:0] c);
    wr(ADDR_A_HI, a[63:32]);
    wr(ADDR_A_LO, a[31:0]);
    wr(ADDR_B_HI, b[63:32]);
    wr(ADDR_B_LO, b[31:0]);
    wr(ADDR_C_HI, c[63:32]);
    wr(ADDR_C_LO, c[31:0]);
  endtask : set_ops
  // Later reads stall behind the operation, so no fixed wait is needed after the start.
  task automatic do_op(input logic [31:0] i, input logic [63:0] ed, input logic [31:0] ef,
    input logic ew);
    logic [31:0] hi;
    logic [31:0] lo;
    logic [31:0] fs;
    int w0;
    w0 = i_fpmau_host_model.wb_count;
    wr(ADDR_INSTR, i);
    rd(ADDR_D_HI, hi);
    rd(ADDR_D_LO, lo);
    rd(ADDR_FP_STATUS_CONTROL_REG, fs);
    `CHK("dest", ed, {hi, lo})
    `CHK("fp_status_control_reg", ef, fs)
    `CHK("wb count", ew ? w0 + 1 : w0, i_fpmau_host_model.wb_count)
    `CHK("wb data", ed, wb_data)
    `CHK("wb index", i[25:21], wb_index)
  endtask : do_op
  task automatic end_test(input string nm);
    $display("test %s done", nm);
  endtask : end_test
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end
  initial begin
    logic [1:0] rn;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_CTRL, q);
    `CHK("ctrl reset", 32'h0, q)
    rd(ADDR_FP_STATUS_CONTROL_REG, q);
    `CHK("fp_status_control_reg reset", 32'h0, q)
    rd(6'h30, q);
    `CHK("unmapped", 32'h0, q)
    wr(6'h30, 32'hffffffff);
    wr(ADDR_D_HI, 32'hffffffff);
    i_fpmau_host_model.bus_write(ADDR_D_HI, 32'h0, 4'h3);
    rd(ADDR_D_HI, q);
    `CHK("byte lanes", 32'hffff0000, q)
    end_test("registers");
    set_ops(64'h40000000_00000000, 64'h3ff00000_00000000, 64'h40080000_00000000);
    wr(ADDR_FP_STATUS_CONTROL_REG, 32'h0);
    do_op(ins(OP_DOUBLE, 5'd3, 5'd1, 5'd0, 5'd2, XO_MUL, 1'b0), 64'h40180000_00000000,
      32'h00004000, 1'b1);
    wr(ADDR_FP_STATUS_CONTROL_REG, 32'h0);
    do_op(ins(OP_DOUBLE, 5'd4, 5'd1, 5'd5, 5'd2, XO_MSUB, 1'b1), 64'h40140000_00000000,
      32'h00004000, 1'b1);
    wr(ADDR_FP_STATUS_CONTROL_REG, 32'h0);
    do_op(ins(OP_SINGLE, 5'd7, 5'd1, 5'd5, 5'd2, XO_MADD, 1'b0), 64'h401c0000_00000000,
      32'h00004000, 1'b1);
    set_ops(64'h3ff80000_00000000, 64'h0, 64'h3ff80000_00000000);
    wr(ADDR_FP_STATUS_CONTROL_REG, 32'h0);
    do_op(ins(OP_DOUBLE, 5'd9, 5'd1, 5'd0, 5'd2, XO_MUL, 1'b0), 64'h40020000_00000000,
      32'h00004000, 1'b1);
    end_test("exact arithmetic");
    for (int k = 0; k < 2; k++) begin
      rn = k ? 2'h2 : 2'h0;
      set_ops(64'h3ff00000_00000001, 64'h0, 64'h3ff00000_00000001);
      wr(ADDR_FP_STATUS_CONTROL_REG, {30'h0, rn});
      do_op(ins(OP_DOUBLE, 5'd10, 5'd1, 5'd0, 5'd2, XO_MUL, 1'b0),
        k ? 64'h3ff00000_00000003 : 64'h3ff00000_00000002,
        k ? 32'h82064002 : 32'h82024000, 1'b1);
      set_ops(64'h3ff00000_00400000, 64'h0, 64'h3ff00000_00000000);
      wr(ADDR_FP_STATUS_CONTROL_REG, {30'h0, rn});
      do_op(ins(OP_SINGLE, 5'd11, 5'd1, 5'd5, 5'd2, XO_MSUB, 1'b0),
        k ? 64'h3ff00000_20000000 : 64'h3ff00000_00000000,
        k ? 32'h82064002 : 32'h82024000, 1'b1);
    end
    end_test("rounding");
    set_ops(64'h7ff00000_00000000, 64'h0, 64'h0);
    wr(ADDR_FP_STATUS_CONTROL_REG, 32'h0);
    do_op(ins(OP_DOUBLE, 5'd12, 5'd1, 5'd0, 5'd2, XO_MUL, 1'b0), 64'h7ff80000_00000000,
      32'ha0111000, 1'b1);
    set_ops(64'h7ff00000_00000000, 64'hfff00000_00000000, 64'h3ff00000_00000000);
    wr(ADDR_FP_STATUS_CONTROL_REG, 32'h0);
    do_op(ins(OP_SINGLE, 5'd13, 5'd1, 5'd5, 5'd2, XO_MADD, 1'b0), 64'h7ff80000_00000000,
      32'ha0811000, 1'b1);
    set_ops(64'h7ff00000_00000000, 64'h0, 64'h0);
    wr(ADDR_D_HI, 32'h55555555);
    wr(ADDR_D_LO, 32'h66666666);
    wr(ADDR_FP_STATUS_CONTROL_REG, 32'h00000080);
    do_op(ins(OP_DOUBLE, 5'd14, 5'd1, 5'd0, 5'd2, XO_MUL, 1'b1), 64'h55555555_66666666,
      32'he0100080, 1'b0);
    rd(ADDR_STATUS, q);
    `CHK("cond field trap", 4'he, q[7:4])
    end_test("invalid operations");
    wr(ADDR_CTRL, 32'h1);
    set_ops(64'h40000000_12345678, 64'h0, 64'h40400000_9abcdef0);
    wr(ADDR_FP_STATUS_CONTROL_REG, 32'h0);
    do_op(ins(OP_SINGLE, 5'd15, 5'd1, 5'd0, 5'd2, XO_MUL, 1'b0), 64'h40c00000_40c00000,
      32'h00004000, 1'b1);
    end_test("paired multiply");
    set_ops(64'h0, 64'h11112222_33334444, 64'h0);
    for (int k = 0; k < 3; k++) begin
      // The third pass needs both paired mode and the paired tag on B to keep the second slot.
      wr(ADDR_CTRL, (k == 2) ? 32'h3 : 32'(k));
      wr(ADDR_D_HI, 32'haaaaaaaa);
      wr(ADDR_D_LO, 32'hbbbbbbbb);
      wr(ADDR_FP_STATUS_CONTROL_REG, 32'ha0000000);
      do_op(ins(OP_DOUBLE, 5'(16 + k), 5'd0, 5'd5, XO_MOVE[9:5], XO_MOVE[4:0], 1'b1),
        (k == 2) ? 64'h11112222_bbbbbbbb : 64'h11112222_33334444,
        32'ha0000000, 1'b1);
      rd(ADDR_STATUS, q);
      `CHK("cond field move", 4'ha, q[7:4])
    end
    end_test("register move");
    wr(ADDR_CTRL, 32'h0);
    wr(ADDR_D_HI, 32'h0);
    wr(ADDR_D_LO, 32'h0);
    wr(ADDR_FP_STATUS_CONTROL_REG, 32'h0);
    do_op(ins(OP_DOUBLE, 5'd20, 5'd1, 5'd5, 5'd2, XO_MADD, 1'b0), 64'h0, 32'h0,
      1'b0);
    rd(ADDR_STATUS, q);
    `CHK("illegal flag", 2'h2, q[1:0])
    end_test("illegal encoding");
    complete_run();
  end
endmodule : tb
